// ===== common/pot_map.svh
// register offsets, reset values and field positions of the pattern
// output enable and trigger select block
// assumes a 6-bit wishbone byte address, one aligned 32-bit word per register
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

`define POT_OFS_LOW_EN 6'h00
`define POT_OFS_HIGH_EN 6'h04
`define POT_OFS_TRIG 6'h08
`define POT_OFS_PORT_A 6'h0C
`define POT_OFS_PORT_B 6'h10

`define POT_RST_LOW_EN 8'h00
`define POT_RST_HIGH_EN 8'h00
`define POT_RST_TRIG 8'hFF
`define POT_RST_PORT 8'h00

`define POT_GRP3_LSB 6
`define POT_GRP2_LSB 4
`define POT_GRP1_LSB 2
`define POT_GRP0_LSB 0

`endif

// ===== common/pot_pkg.sv
// shared types of the pattern output enable and trigger select block
// assumes pot_map.svh supplies offsets and reset values
package pot_pkg;
	typedef logic [7:0] pot_byte_t;
	typedef enum logic [1:0] {
		POT_CH0 = 2'h0,
		POT_CH1 = 2'h1,
		POT_CH2 = 2'h2,
		POT_CH3 = 2'h3
	} pot_chan_e;
endpackage

// ===== logic/pot_group.sv
// one group of four pattern outputs: trigger pick and data latch
// assumes strobes and next data come from logic on core_clk
`timescale 1ns/1ns
module pot_group
	import pot_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic [1:0] trig_sel,
	input wire logic [3:0] cmp_match,
	input wire logic [3:0] enable,
	input wire logic [3:0] next_data,
	input wire logic sw_write,
	input wire logic [3:0] sw_data,
	output logic [3:0] latch
);
	pot_chan_e chan;
	logic fire;
	logic [3:0] next_latch;

	assign chan = pot_chan_e'(trig_sel);

	always_comb begin
		case (chan)
			POT_CH0: fire = cmp_match[0];
			POT_CH1: fire = cmp_match[1];
			POT_CH2: fire = cmp_match[2];
			POT_CH3: fire = cmp_match[3];
			default: fire = 1'b0;
		endcase
	end

	always_comb begin
		next_latch = latch;
		// write lock; enabled bits refuse software data
		if (sw_write) begin
			next_latch = (latch & enable) | (sw_data & ~enable);
		end
		if (fire) begin
			next_latch = (next_latch & ~enable) | (next_data & enable);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch <= 4'h0;
		end else if (clear) begin
			latch <= 4'h0;
		end else begin
			latch <= next_latch;
		end
	end
endmodule

// ===== logic/pot_top.sv
// pattern output enable and trigger select with its port data latches
// assumes timer strobes, next data and port direction are on core_clk;
// registers reached over a classic wishbone slave, 8-bit data in lane 0
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "pot_map.svh"

// Summary of operation
// - enabled low outputs copy next data into port A latch on trigger
// - disabled low outputs keep port A latch bit unchanged on trigger
// - low enable register clears on reset and hardware standby only
// - enabled high outputs copy next data into port B latch on trigger
// - disabled high outputs keep port B latch bit unchanged on trigger
// - high enable register clears on reset and hardware standby only
// - trigger select resets to all ones, channel 3 for every group
// - select bits 7:6 pick the timer channel for outputs 15 to 12
// - select bits 5:4 pick the timer channel for outputs 11 to 8
// - select bits 3:2 pick the timer channel for outputs 7 to 4
// - select bits 1:0 pick the timer channel for outputs 3 to 0
// - trigger per group, enable per bit, all registers read and write
// - enabled latch bits ignore software writes, only transfers, reset and hardware standby change them
// - transfer still happens while the pin direction is input
module pot_top
	import pot_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hw_standby,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] cmp_match_a,
	input wire logic [7:0] low_next_data,
	input wire logic [7:0] high_next_data,
	input wire logic [15:0] port_dir,
	output logic [15:0] pattern_out,
	output logic [15:0] pattern_oe
);
	pot_byte_t low_next_data_enable;
	pot_byte_t high_next_data_enable;
	pot_byte_t group_trigger_select;
	logic [7:0] port_a_latch;
	logic [7:0] port_b_latch;
	logic [15:0] all_enable;
	logic [15:0] all_next;
	logic [15:0] all_latch;
	logic bus_req;
	logic bus_write;
	logic wr_port_a;
	logic wr_port_b;
	logic [31:0] next_rd_data;

	assign bus_req = wb_cyc_i && wb_stb_i;
	// a write lands on the edge that sees ack, like the master takes it
	assign bus_write = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign wr_port_a = bus_write && (wb_adr_i == `POT_OFS_PORT_A);
	assign wr_port_b = bus_write && (wb_adr_i == `POT_OFS_PORT_B);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
		end
	end

	always_comb begin
		case (wb_adr_i)
			`POT_OFS_LOW_EN: next_rd_data = {24'h00_0000, low_next_data_enable};
			`POT_OFS_HIGH_EN: next_rd_data = {24'h00_0000, high_next_data_enable};
			`POT_OFS_TRIG: next_rd_data = {24'h00_0000, group_trigger_select};
			`POT_OFS_PORT_A: next_rd_data = {24'h00_0000, port_a_latch};
			`POT_OFS_PORT_B: next_rd_data = {24'h00_0000, port_b_latch};
			default: next_rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_ack_o && !wb_we_i) begin
			wb_dat_o <= next_rd_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_next_data_enable <= `POT_RST_LOW_EN;
		end else if (hw_standby) begin
			low_next_data_enable <= `POT_RST_LOW_EN;
		end else if (bus_write && wb_adr_i == `POT_OFS_LOW_EN) begin
			low_next_data_enable <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_next_data_enable <= `POT_RST_HIGH_EN;
		end else if (hw_standby) begin
			high_next_data_enable <= `POT_RST_HIGH_EN;
		end else if (bus_write && wb_adr_i == `POT_OFS_HIGH_EN) begin
			high_next_data_enable <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			group_trigger_select <= `POT_RST_TRIG;
		end else if (hw_standby) begin
			group_trigger_select <= `POT_RST_TRIG;
		end else if (bus_write && wb_adr_i == `POT_OFS_TRIG) begin
			group_trigger_select <= wb_dat_i[7:0];
		end
	end

	// direction only shapes the pin driver, latch runs anyway
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pattern_oe <= 16'h0000;
		end else begin
			pattern_oe <= port_dir;
		end
	end

	assign all_enable = {high_next_data_enable, low_next_data_enable};
	assign all_next = {high_next_data, low_next_data};

	// one trigger per group of four
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : grp
			pot_group u_group (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.clear(hw_standby),
				.trig_sel(group_trigger_select[2*g+1:2*g]),
				.cmp_match(cmp_match_a),
				.enable(all_enable[4*g+3:4*g]),
				.next_data(all_next[4*g+3:4*g]),
				.sw_write(g < 2 ? wr_port_a : wr_port_b),
				.sw_data(wb_dat_i[4*(g%2)+3:4*(g%2)]),
				.latch(all_latch[4*g+3:4*g])
			);
		end
	endgenerate

	assign port_a_latch = all_latch[7:0];
	assign port_b_latch = all_latch[15:8];
	assign pattern_out = all_latch;

	// helper: which bits a trigger moves this cycle
	logic [15:0] xfer_mask;
	always_comb begin
		xfer_mask = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			xfer_mask[i] = all_enable[i]
				&& cmp_match_a[group_trigger_select[2*(i/4) +: 2]];
		end
	end

	default clocking pot_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	chk_low_copy: assert property (
		!hw_standby |=> ((pattern_out[7:0] & $past(xfer_mask[7:0]))
		== ($past(low_next_data) & $past(xfer_mask[7:0]))))
		else $error("low enabled bit missed its transfer");

	chk_low_hold: assert property (
		(!hw_standby && !wr_port_a) |=>
		((pattern_out[7:0] & ~$past(xfer_mask[7:0]))
		== ($past(pattern_out[7:0]) & ~$past(xfer_mask[7:0]))))
		else $error("low disabled bit changed without a write");

	chk_low_clear: assert property (
		hw_standby |=> low_next_data_enable == 8'h00)
		else $error("low enable not cleared by standby");

	chk_high_copy: assert property (
		!hw_standby |=> ((pattern_out[15:8] & $past(xfer_mask[15:8]))
		== ($past(high_next_data) & $past(xfer_mask[15:8]))))
		else $error("high enabled bit missed its transfer");

	chk_high_hold: assert property (
		(!hw_standby && !wr_port_b) |=>
		((pattern_out[15:8] & ~$past(xfer_mask[15:8]))
		== ($past(pattern_out[15:8]) & ~$past(xfer_mask[15:8]))))
		else $error("high disabled bit changed without a write");

	chk_high_clear: assert property (
		hw_standby |=> high_next_data_enable == 8'h00)
		else $error("high enable not cleared by standby");

	chk_trig_preset: assert property (
		hw_standby |=> group_trigger_select == 8'hFF)
		else $error("trigger select not preset by standby");

	chk_grp3_chan: assert property (
		(!hw_standby && high_next_data_enable[7:4] != 4'h0
		&& cmp_match_a == (4'b0001 << group_trigger_select[7:6]))
		|=> ((pattern_out[15:12] & $past(high_next_data_enable[7:4]))
		== ($past(high_next_data[7:4])
		& $past(high_next_data_enable[7:4]))))
		else $error("group 3 ignored its channel");

	chk_grp2_chan: assert property (
		(!hw_standby && high_next_data_enable[3:0] != 4'h0
		&& cmp_match_a == (4'b0001 << group_trigger_select[5:4]))
		|=> ((pattern_out[11:8] & $past(high_next_data_enable[3:0]))
		== ($past(high_next_data[3:0])
		& $past(high_next_data_enable[3:0]))))
		else $error("group 2 ignored its channel");

	chk_grp1_chan: assert property (
		(!hw_standby && low_next_data_enable[7:4] != 4'h0
		&& cmp_match_a == (4'b0001 << group_trigger_select[3:2]))
		|=> ((pattern_out[7:4] & $past(low_next_data_enable[7:4]))
		== ($past(low_next_data[7:4])
		& $past(low_next_data_enable[7:4]))))
		else $error("group 1 ignored its channel");

	chk_grp0_chan: assert property (
		(!hw_standby && low_next_data_enable[3:0] != 4'h0
		&& cmp_match_a == (4'b0001 << group_trigger_select[1:0]))
		|=> ((pattern_out[3:0] & $past(low_next_data_enable[3:0]))
		== ($past(low_next_data[3:0])
		& $past(low_next_data_enable[3:0]))))
		else $error("group 0 ignored its channel");

	chk_trig_read: assert property (
		(bus_req && !wb_we_i && !wb_ack_o && wb_adr_i == `POT_OFS_TRIG)
		|=> wb_ack_o && wb_dat_o == {24'h00_0000,
		$past(group_trigger_select)})
		else $error("trigger select read back wrong");

	chk_latch_locked: assert property (
		(wr_port_a && !hw_standby && cmp_match_a == 4'h0)
		|=> (pattern_out[7:0] == (($past(pattern_out[7:0])
		& $past(low_next_data_enable)) | ($past(wb_dat_i[7:0])
		& ~$past(low_next_data_enable)))))
		else $error("enabled latch bit took a software write");

	chk_input_xfer: assert property (
		(port_dir[7:0] == 8'h00 && xfer_mask[7:0] != 8'h00 && !hw_standby)
		|=> ((pattern_out[7:0] & $past(xfer_mask[7:0]))
		== ($past(low_next_data) & $past(xfer_mask[7:0]))
		&& pattern_oe[7:0] == 8'h00))
		else $error("transfer lost while pin is input");

	chk_strobe_edge: assert property (
		(!hw_standby && cmp_match_a == 4'h0 && !wr_port_a && !wr_port_b)
		|=> $stable(pattern_out))
		else $error("latch moved without strobe or write");

	chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	cov_low_xfer: cover property (@(posedge core_clk) disable iff (!rst_n)
		xfer_mask[7:0] != 8'h00);
	cov_high_xfer: cover property (@(posedge core_clk) disable iff (!rst_n)
		xfer_mask[15:8] != 8'h00);
	cov_locked_wr: cover property (@(posedge core_clk) disable iff (!rst_n)
		wr_port_b && high_next_data_enable != 8'h00);
	cov_standby: cover property (@(posedge core_clk) disable iff (!rst_n)
		hw_standby && group_trigger_select != 8'hFF);
endmodule

// ===== sim/pot_timer_model.sv
// timer unit stand-in: one-cycle compare strobe per channel on request
// assumes the bench pulses fire for one cycle on core_clk
`timescale 1ns/1ns
module pot_timer_model
	import pot_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire pot_chan_e chan,
	input wire logic [3:0] delay,
	output logic [3:0] cmp_match
);
	logic busy;
	logic [3:0] cnt;
	pot_chan_e chan_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			chan_q <= POT_CH0;
			cmp_match <= 4'h0;
		end else begin
			cmp_match <= 4'h0;
			if (fire) begin
				busy <= 1'b1;
				cnt <= delay;
				chan_q <= chan;
			end else if (busy && cnt == 4'h0) begin
				cmp_match <= 4'h1 << chan_q;
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

// ===== sim/tb.sv
// bench: register access over wishbone, timer strobes from the model
// assumes pot_top answers every bus request one cycle after it
`timescale 1ns/1ns
`include "pot_map.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
	err_count++; $display("wrong value at %0t: %h %h", $time, got, exp); end end
module tb
	import pot_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n, hw_standby, cyc, stb, we, fire, ack;
	logic [5:0] adr;
	logic [31:0] dat, rdat;
	logic [3:0] cmp, delay;
	logic [7:0] low_nd, high_nd;
	logic [15:0] port_dir, pout, poe, en, expo;
	pot_byte_t sel;
	pot_chan_e chan;
	int err_count = 0;
	int check_count = 0;
	always #4 core_clk = ~core_clk;
	pot_timer_model u_pot_timer_model (.core_clk(core_clk), .rst_n(rst_n),
		.fire(fire), .chan(chan), .delay(delay), .cmp_match(cmp));
	pot_top u_pot_top (.core_clk(core_clk), .rst_n(rst_n),
		.hw_standby(hw_standby), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cmp_match_a(cmp),
		.low_next_data(low_nd), .high_next_data(high_nd),
		.port_dir(port_dir), .pattern_out(pout), .pattern_oe(poe));
	task automatic end_of_test();
		if (err_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [5:0] a,
		input pot_byte_t d, output pot_byte_t q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) begin
			err_count++;
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [5:0] a, input pot_byte_t d);
		pot_byte_t q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input pot_byte_t e);
		pot_byte_t q;
		xfer(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	// strobe one channel, then predict which latch bits moved
	task automatic trig(input logic [1:0] ch, input logic [3:0] dly,
		input logic [15:0] nd);
		int n;
		logic [15:0] m;
		low_nd <= nd[7:0];
		high_nd <= nd[15:8];
		fire <= 1'b1;
		chan <= pot_chan_e'(ch);
		delay <= dly;
		@(posedge core_clk);
		fire <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (cmp === 4'h0 && n < 40);
		if (cmp === 4'h0) begin
			err_count++;
		end
		m = 16'h0000;
		for (int g = 0; g < 4; g++) begin
			if (sel[2*g +: 2] == ch) m[4*g +: 4] = 4'hF;
		end
		expo = (expo & ~(m & en)) | (nd & m & en);
		#1;
		`CHK(pout, expo)
		@(posedge core_clk);
	endtask
	initial begin
		rst_n = 1'b0;
		{hw_standby, cyc, stb, we, fire} = 5'h00;
		{adr, dat, delay, low_nd, high_nd, port_dir} = '0;
		chan = POT_CH0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(`POT_OFS_LOW_EN, 8'h00);
		rd(`POT_OFS_HIGH_EN, 8'h00);
		rd(`POT_OFS_TRIG, 8'hFF);
		rd(6'h14, 8'h00);
		wr(`POT_OFS_LOW_EN, 8'h0F);
		wr(`POT_OFS_HIGH_EN, 8'hF0);
		{en, sel, expo} = {16'hF00F, 8'hFF, 16'h0000};
		rd(`POT_OFS_LOW_EN, 8'h0F);
		rd(`POT_OFS_HIGH_EN, 8'hF0);
		trig(2'd3, 4'd0, 16'hA5C3);
		// enabled bits must hold against the write
		wr(`POT_OFS_PORT_A, 8'hFF);
		expo[7:4] = 4'hF;
		rd(`POT_OFS_PORT_A, expo[7:0]);
		wr(`POT_OFS_PORT_B, 8'h0F);
		expo[11:8] = 4'hF;
		rd(`POT_OFS_PORT_B, expo[15:8]);
		port_dir <= 16'h00FF;
		wr(`POT_OFS_LOW_EN, 8'hA5);
		wr(`POT_OFS_HIGH_EN, 8'h5A);
		en = 16'h5AA5;
		`CHK(poe, 16'h00FF)
		// every group sees a different channel, rotated each round
		for (int r = 0; r < 4; r++) begin
			sel = {2'(r + 3), 2'(r + 2), 2'(r + 1), 2'(r)};
			wr(`POT_OFS_TRIG, sel);
			rd(`POT_OFS_TRIG, sel);
			for (int c = 0; c < 4; c++) begin
				trig(2'(c), 4'(c * 3), 16'(16'h1357 * (r * 4 + c + 1)));
			end
		end
		rd(`POT_OFS_PORT_B, expo[15:8]);
		hw_standby <= 1'b1;
		@(posedge core_clk);
		hw_standby <= 1'b0;
		@(posedge core_clk);
		`CHK(pout, 16'h0000)
		rd(`POT_OFS_LOW_EN, 8'h00);
		rd(`POT_OFS_HIGH_EN, 8'h00);
		rd(`POT_OFS_TRIG, 8'hFF);
		end_of_test();
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule
